// ===== hdl/scdu_host.v
// Host controller that programs the scaler's dynamic parameter bank.
// Assumes the scaler's parameter bus runs on clk (no separate clock), 32 bits wide.
`timescale 1ns/1ps
`include "scdu_defs.vh"

// How it works
// - Input width field is width minus one
// - 4:2:2 input width field must be odd
// - Input height field is height minus one
// - Output width field is width minus one
// - 4:2:2 output width field must be odd
// - Output height field is height minus one
// - Vertical factor from heights and phase width
// - Horizontal factor from widths and phase width
// - Set update request after all writes
// - Write parameters only while request reads zero
// - Valid data with write; low address bits zero
module scdu_host #(
   parameter MAX_IN_W    = 1920,
   parameter MAX_IN_H    = 1080,
   parameter MAX_OUT_W   = 1920,
   parameter MAX_OUT_H   = 1080,
   parameter V_PHASES    = 16,
   parameter H_PHASES    = 16,
   parameter V_COEF_W    = 9,
   parameter H_COEF_W    = 9,
   parameter SMALL_KERN  = 0
) (
   input  wire        clk,
   input  wire        arst_n,
   input  wire [3:0]  sw_addr,
   input  wire [31:0] sw_wdata,
   input  wire        sw_wr,
   input  wire        sw_rd,
   output reg  [31:0] sw_rdata,
   output reg         pwrite,
   output reg  [4:0]  paddr,
   output reg  [31:0] pwdat,
   input  wire [31:0] prdat
);
   // Ceiling log2 for the phase-bit widths
   function integer clog2;
      input integer v;
      integer n;
      begin
         n = 0;
         while ((1 << n) < v)
            n = n + 1;
         clog2 = n;
      end
   endfunction

   // Phase-bit widths as the device derives them for a dynamic scaler
   localparam VB0 = (V_PHASES > MAX_OUT_H) ? clog2(V_PHASES) : clog2(MAX_OUT_H);
   localparam HB0 = (H_PHASES > MAX_OUT_W) ? clog2(H_PHASES) : clog2(MAX_OUT_W);
   localparam VBITS = (SMALL_KERN != 0 && VB0 < V_COEF_W) ? V_COEF_W : VB0;
   localparam HBITS = (SMALL_KERN != 0 && HB0 < H_COEF_W) ? H_COEF_W : HB0;

   localparam [15:0] IW_MAX = MAX_IN_W - 1;
   localparam [15:0] IH_MAX = MAX_IN_H - 1;
   localparam [15:0] OW_MAX = MAX_OUT_W - 1;
   localparam [15:0] OH_MAX = MAX_OUT_H - 1;

   // Sequencer states
   localparam [3:0] ST_IDLE  = 4'h0;
   localparam [3:0] ST_POLL  = 4'h1;
   localparam [3:0] ST_CHECK = 4'h2;
   localparam [3:0] ST_CALC  = 4'h3;
   localparam [3:0] ST_WRITE = 4'h4;
   localparam [3:0] ST_REQ   = 4'h5;
   localparam [3:0] ST_WAIT  = 4'h6;
   localparam [3:0] ST_RDREQ = 4'h7;
   localparam [3:0] ST_RDCHK = 4'h8;
   localparam [3:0] ST_GAP   = 4'h9;

   reg [15:0] iw_r;
   reg [15:0] ih_r;
   reg [15:0] ow_r;
   reg [15:0] oh_r;
   reg        yuv_r;
   reg        busy_r;
   reg        err_r;
   reg        pend_r;
   reg [3:0]  state_r;
   reg [2:0]  idx_r;
   reg [7:0]  gap_r;
   reg        calc_go_r;
   reg [1:0]  calc_done_r;
   reg        go_q_r;
   wire [31:0] vfac;
   wire [31:0] hfac;
   wire        vdone;
   wire        hdone;
   wire        go_req;
   wire        bad_cfg;
   reg  [31:0] rd_mux;
   reg  [4:0]  wr_addr;
   reg  [31:0] wr_data;

   assign go_req = sw_wr && (sw_addr == `SCDU_CMD_CONTROL) && sw_wdata[`SCDU_CTL_GO_BIT];

   // Range and 4:2:2 parity check after the request poll, before any device write
   assign bad_cfg = (iw_r < `SCDU_MIN_FIELD) || (iw_r > IW_MAX) ||
                    (ih_r < `SCDU_MIN_FIELD) || (ih_r > IH_MAX) ||
                    (ow_r < `SCDU_MIN_FIELD) || (ow_r > OW_MAX) ||
                    (oh_r < `SCDU_MIN_FIELD) || (oh_r > OH_MAX) ||
                    (yuv_r && !iw_r[0]) ||
                    (yuv_r && !ow_r[0]);

   // Factor dividers
   scdu_factor #(.SIZE_W(16), .PHASE_W(VBITS)) u_vfac (
      .clk       (clk),
      .arst_n    (arst_n),
      .start     (calc_go_r),
      .in_field  (ih_r),
      .out_field (oh_r),
      .factor    (vfac),
      .done      (vdone)
   );
   scdu_factor #(.SIZE_W(16), .PHASE_W(HBITS)) u_hfac (
      .clk       (clk),
      .arst_n    (arst_n),
      .start     (calc_go_r),
      .in_field  (iw_r),
      .out_field (ow_r),
      .factor    (hfac),
      .done      (hdone)
   );

   // Register order written to the device; all six every time
   always @* begin
      case (idx_r)
         3'h0: begin
            wr_addr = `SCDU_DEV_IN_WIDTH;
            wr_data = {16'h0000, iw_r};
         end
         3'h1: begin
            wr_addr = `SCDU_DEV_IN_HEIGHT;
            wr_data = {16'h0000, ih_r};
         end
         3'h2: begin
            wr_addr = `SCDU_DEV_OUT_WIDTH;
            wr_data = {16'h0000, ow_r};
         end
         3'h3: begin
            wr_addr = `SCDU_DEV_OUT_HEIGHT;
            wr_data = {16'h0000, oh_r};
         end
         3'h4: begin
            wr_addr = `SCDU_DEV_VSCALE;
            wr_data = vfac;
         end
         default: begin
            wr_addr = `SCDU_DEV_HSCALE;
            wr_data = hfac;
         end
      endcase
   end

   // Software read mux
   always @* begin
      case (sw_addr)
         `SCDU_CMD_IN_WIDTH:   rd_mux = {16'h0000, iw_r};
         `SCDU_CMD_IN_HEIGHT:  rd_mux = {16'h0000, ih_r};
         `SCDU_CMD_OUT_WIDTH:  rd_mux = {16'h0000, ow_r};
         `SCDU_CMD_OUT_HEIGHT: rd_mux = {16'h0000, oh_r};
         `SCDU_CMD_CONTROL:    rd_mux = {30'h00000000, yuv_r, 1'b0};
         `SCDU_CMD_STATUS:     rd_mux = {29'h00000000, pend_r, err_r, busy_r};
         `SCDU_CMD_VSCALE:     rd_mux = vfac;
         `SCDU_CMD_HSCALE:     rd_mux = hfac;
         default:              rd_mux = 32'h00000000;
      endcase
   end

   // Software-facing registers; staged sizes start at the device's maxima
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         iw_r     <= IW_MAX;
         ih_r     <= IH_MAX;
         ow_r     <= OW_MAX;
         oh_r     <= OH_MAX;
         yuv_r    <= 1'b0;
         sw_rdata <= 32'h00000000;
         go_q_r   <= 1'b0;
      end else begin
         go_q_r   <= 1'b0;
         sw_rdata <= sw_rd ? rd_mux : 32'h00000000;
         // Size fields are frozen while a sequence runs
         if (sw_wr && !busy_r) begin
            case (sw_addr)
               `SCDU_CMD_IN_WIDTH:   iw_r <= sw_wdata[15:0];
               `SCDU_CMD_IN_HEIGHT:  ih_r <= sw_wdata[15:0];
               `SCDU_CMD_OUT_WIDTH:  ow_r <= sw_wdata[15:0];
               `SCDU_CMD_OUT_HEIGHT: oh_r <= sw_wdata[15:0];
               `SCDU_CMD_CONTROL: begin
                  yuv_r  <= sw_wdata[`SCDU_CTL_YUV422_BIT];
                  go_q_r <= go_req;
               end
               default: ;
            endcase
         end
      end
   end

   // Sequencer: poll request bit, compute, write six, set request, wait clear
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r     <= ST_IDLE;
         idx_r       <= 3'h0;
         gap_r       <= 8'h00;
         calc_go_r   <= 1'b0;
         calc_done_r <= 2'b00;
         busy_r      <= 1'b0;
         err_r       <= 1'b0;
         pend_r      <= 1'b0;
         pwrite      <= 1'b0;
         paddr       <= 5'h00;
         pwdat       <= 32'h00000000;
      end else begin
         pwrite    <= 1'b0;
         calc_go_r <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (go_q_r) begin
                  busy_r  <= 1'b1;
                  err_r   <= 1'b0;
                  paddr   <= `SCDU_DEV_UPDATE;
                  state_r <= ST_POLL;
               end
            end
            ST_POLL: begin
               // Address held one cycle; data returns next cycle
               state_r <= ST_CHECK;
            end
            ST_CHECK: begin
               pend_r <= 1'b0; // Follows the latest poll, even on a refused config
               if (prdat[0]) begin
                  // Earlier update still pending: retry later
                  pend_r  <= 1'b1;
                  gap_r   <= `SCDU_POLL_GAP;
                  state_r <= ST_GAP;
               end else if (bad_cfg) begin
                  err_r   <= 1'b1;
                  busy_r  <= 1'b0;
                  state_r <= ST_IDLE;
               end else begin
                  calc_go_r   <= 1'b1;
                  calc_done_r <= 2'b00;
                  state_r     <= ST_CALC;
               end
            end
            ST_GAP: begin
               gap_r <= gap_r - 8'h01;
               if (gap_r == 8'h01) begin
                  paddr   <= `SCDU_DEV_UPDATE;
                  state_r <= ST_POLL;
               end
            end
            ST_CALC: begin
               calc_done_r <= calc_done_r | {hdone, vdone};
               if ((calc_done_r | {hdone, vdone}) == 2'b11 && !vdone && !hdone) begin
                  idx_r   <= 3'h0;
                  state_r <= ST_WRITE;
               end
            end
            ST_WRITE: begin
               // Only entered with the request bit read as zero
               pwrite <= 1'b1;
               paddr  <= wr_addr;
               pwdat  <= wr_data;
               idx_r  <= idx_r + 3'h1;
               if (idx_r == 3'h5)
                  state_r <= ST_REQ;
            end
            ST_REQ: begin
               pwrite  <= 1'b1;
               paddr   <= `SCDU_DEV_UPDATE;
               pwdat   <= 32'h00000001;
               pend_r  <= 1'b1;
               gap_r   <= `SCDU_POLL_GAP;
               state_r <= ST_WAIT;
            end
            ST_WAIT: begin
               gap_r <= gap_r - 8'h01;
               if (gap_r == 8'h01) begin
                  paddr   <= `SCDU_DEV_UPDATE;
                  state_r <= ST_RDREQ;
               end
            end
            ST_RDREQ: begin
               state_r <= ST_RDCHK;
            end
            ST_RDCHK: begin
               // Device clears the bit after loading at frame sync
               if (!prdat[0]) begin
                  pend_r  <= 1'b0;
                  busy_r  <= 1'b0;
                  state_r <= ST_IDLE;
               end else begin
                  gap_r   <= `SCDU_POLL_GAP;
                  state_r <= ST_WAIT;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end
endmodule // scdu_host

// ===== pkg/scdu_defs.vh
// Register map and timing constants of the scaler parameter-update controller.
// Assumes a 32-bit parameter bus with byte addresses on a 5-bit address.
`ifndef SCDU_DEFS_VH
`define SCDU_DEFS_VH

// Device register offsets on the parameter bus
`define SCDU_DEV_IN_WIDTH     5'h00
`define SCDU_DEV_IN_HEIGHT    5'h04
`define SCDU_DEV_OUT_WIDTH    5'h08
`define SCDU_DEV_OUT_HEIGHT   5'h0c
`define SCDU_DEV_VSCALE       5'h10
`define SCDU_DEV_HSCALE       5'h14
`define SCDU_DEV_UPDATE       5'h18

// Smallest legal size field value
`define SCDU_MIN_FIELD        16'h001f

// Host-side command register offsets
`define SCDU_CMD_IN_WIDTH     4'h0
`define SCDU_CMD_IN_HEIGHT    4'h1
`define SCDU_CMD_OUT_WIDTH    4'h2
`define SCDU_CMD_OUT_HEIGHT   4'h3
`define SCDU_CMD_CONTROL      4'h4
`define SCDU_CMD_STATUS       4'h5
`define SCDU_CMD_VSCALE       4'h6
`define SCDU_CMD_HSCALE       4'h7

// Control and status bit positions
`define SCDU_CTL_GO_BIT       0
`define SCDU_CTL_YUV422_BIT   1
`define SCDU_ST_BUSY_BIT      0
`define SCDU_ST_ERR_BIT       1
`define SCDU_ST_PEND_BIT      2

// Poll spacing in cycles while waiting for the device to clear its request
`define SCDU_POLL_GAP         8'h10

`endif

// ===== hdl/scdu_factor.v
// Sequential divider computing one scaling factor.
// Assumes operands stay stable from start until done.
`timescale 1ns/1ps
module scdu_factor #(
   parameter SIZE_W  = 16,
   parameter PHASE_W = 11
) (
   input  wire              clk,
   input  wire              arst_n,
   input  wire              start,
   input  wire [SIZE_W-1:0] in_field,
   input  wire [SIZE_W-1:0] out_field,
   output reg  [31:0]       factor,
   output reg               done
);
   localparam NUM_W = SIZE_W + 1 + PHASE_W;
   localparam [5:0] NUM_CNT = NUM_W;

   reg [NUM_W-1:0] num_r;
   reg [NUM_W:0]   rem_r;
   reg [SIZE_W:0]  den_r;
   reg [5:0]       cnt_r;
   reg             run_r;
   wire [NUM_W:0]  rem_sh;
   wire [NUM_W:0]  den_ext;

   assign rem_sh  = {rem_r[NUM_W-1:0], num_r[NUM_W-1]};
   assign den_ext = {{(NUM_W-SIZE_W){1'b0}}, den_r};

   // Restoring division, one quotient bit per cycle
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         num_r  <= {NUM_W{1'b0}};
         rem_r  <= {(NUM_W+1){1'b0}};
         den_r  <= {(SIZE_W+1){1'b0}};
         cnt_r  <= 6'h00;
         run_r  <= 1'b0;
         factor <= 32'h00000000;
         done   <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            // (field+1) << phase width over (field+1)
            num_r <= {({1'b0, in_field} + {{SIZE_W{1'b0}}, 1'b1}), {PHASE_W{1'b0}}};
            den_r <= {1'b0, out_field} + {{SIZE_W{1'b0}}, 1'b1};
            rem_r <= {(NUM_W+1){1'b0}};
            cnt_r <= NUM_CNT;
            run_r <= 1'b1;
         end else if (run_r) begin
            if (rem_sh >= den_ext) begin
               rem_r <= rem_sh - den_ext;
               num_r <= {num_r[NUM_W-2:0], 1'b1};
            end else begin
               rem_r <= rem_sh;
               num_r <= {num_r[NUM_W-2:0], 1'b0};
            end
            cnt_r <= cnt_r - 6'h01;
            if (cnt_r == 6'h01) begin
               run_r <= 1'b0;
               done  <= 1'b1;
            end
         end else if (done) begin
            factor <= {{(32-NUM_W){1'b0}}, num_r};
         end
      end
   end
endmodule // scdu_factor

// ===== verif/scdu_host_assertions.sv
// Port checker for the scaler parameter-update host controller.
// Assumes it is bound into scdu_host and shares its clock and reset.
`timescale 1ns/1ps
module scdu_host_assertions #(
   parameter MAX_IN_W   = 1920,
   parameter MAX_IN_H   = 1080,
   parameter MAX_OUT_W  = 1920,
   parameter MAX_OUT_H  = 1080,
   parameter V_PHASES   = 16,
   parameter H_PHASES   = 16,
   parameter V_COEF_W   = 9,
   parameter H_COEF_W   = 9,
   parameter SMALL_KERN = 0
) (
   input wire        clk,
   input wire        arst_n,
   input wire [3:0]  sw_addr,
   input wire [31:0] sw_wdata,
   input wire        sw_wr,
   input wire        sw_rd,
   input wire [31:0] sw_rdata,
   input wire        pwrite,
   input wire [4:0]  paddr,
   input wire [31:0] pwdat,
   input wire [31:0] prdat
);
   localparam VB = ($clog2(MAX_OUT_H) > $clog2(V_PHASES)) ? $clog2(MAX_OUT_H) : $clog2(V_PHASES);
   localparam HB = ($clog2(MAX_OUT_W) > $clog2(H_PHASES)) ? $clog2(MAX_OUT_W) : $clog2(H_PHASES);
   localparam PB_V = (SMALL_KERN != 0 && VB < V_COEF_W) ? V_COEF_W : VB;
   localparam PB_H = (SMALL_KERN != 0 && HB < H_COEF_W) ? H_COEF_W : HB;
   reg  [31:0] sz_r [0:3];
   reg         pend_r;
   reg         poll_r;
   integer     k;
   wire [31:0] vexp = ((sz_r[1] + 32'h1) << PB_V) / (sz_r[3] + 32'h1);
   wire [31:0] hexp = ((sz_r[0] + 32'h1) << PB_H) / (sz_r[2] + 32'h1);
   wire [31:0] lim  = (paddr == 5'h00) ? MAX_IN_W - 1 : (paddr == 5'h04) ? MAX_IN_H - 1 :
                      (paddr == 5'h08) ? MAX_OUT_W - 1 : MAX_OUT_H - 1;
   // Sizes last sent, and whether the device still owes the update
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (k = 0; k < 4; k = k + 1) sz_r[k] <= 32'h0;
         pend_r <= 1'b0;
         poll_r <= 1'b0;
      end else begin
         poll_r <= (paddr == 5'h18);
         if (pwrite && paddr < 5'h10) sz_r[paddr[3:2]] <= pwdat;
         if (pwrite && paddr == 5'h18 && pwdat[0]) pend_r <= 1'b1;
         else if (poll_r && !prdat[0]) pend_r <= 1'b0;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence s_rest;
      (pwrite && paddr == 5'h04) ##1 (pwrite && paddr == 5'h08) ##1 (pwrite && paddr == 5'h0c)
         ##1 (pwrite && paddr == 5'h10) ##1 (pwrite && paddr == 5'h14);
   endsequence
   sequence s_request;
      pwrite && paddr == 5'h18 && pwdat == 32'h1;
   endsequence
   a_param_burst: assert property (pwrite && paddr == 5'h00 |=> s_rest ##1 s_request)
      else $error("parameter burst broken");
   a_addr_align: assert property (paddr[1:0] == 2'b00)
      else $error("parameter address not word aligned");
   a_update_one: assert property (pwrite && paddr == 5'h18 |-> pwdat == 32'h1)
      else $error("update request not one");
   a_wait_clear: assert property (pwrite && paddr != 5'h18 |-> !pend_r)
      else $error("parameter written while update pending");
   a_size_range: assert property (pwrite && paddr < 5'h10 |-> pwdat >= 32'h1f && pwdat <= lim)
      else $error("size field out of range");
   a_vert_factor: assert property (pwrite && paddr == 5'h10 |-> pwdat == vexp)
      else $error("vertical factor wrong");
   a_horiz_factor: assert property (pwrite && paddr == 5'h14 |-> pwdat == hexp)
      else $error("horizontal factor wrong");
   a_rdata_slot: assert property (sw_rdata != 32'h0 |-> $past(sw_rd))
      else $error("read data outside its slot");
endmodule // scdu_host_assertions

bind scdu_host scdu_host_assertions #(
   .MAX_IN_W(MAX_IN_W), .MAX_IN_H(MAX_IN_H), .MAX_OUT_W(MAX_OUT_W), .MAX_OUT_H(MAX_OUT_H),
   .V_PHASES(V_PHASES), .H_PHASES(H_PHASES), .V_COEF_W(V_COEF_W), .H_COEF_W(H_COEF_W),
   .SMALL_KERN(SMALL_KERN)) chk_inst (
   .clk(clk), .arst_n(arst_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
   .sw_rd(sw_rd), .sw_rdata(sw_rdata), .pwrite(pwrite), .paddr(paddr), .pwdat(pwdat),
   .prdat(prdat));

// ===== verif/scdu_dev_model.sv
// Behavioural parameter bank of the scaler, as seen by the host.
// Assumes the parameter bus shares clk with the host and is 32 bits wide.
`timescale 1ns/1ps
module scdu_dev_model #(
   parameter MAX_IN_W  = 256,
   parameter MAX_IN_H  = 256,
   parameter MAX_OUT_W = 256,
   parameter MAX_OUT_H = 256,
   parameter FS_GAP    = 300
) (
   input  wire        clk,
   input  wire        arst_n,
   input  wire        pwrite,
   input  wire [4:0]  paddr,
   input  wire [31:0] pwdat,
   output wire [31:0] prdat
);
   reg  [31:0] stage_r [0:6];
   reg  [31:0] work_r  [0:5];
   reg  [4:0]  radr_r;
   reg  [15:0] fs_cnt_r;
   reg  [31:0] bad_wr_r;
   integer     k;
   wire [2:0]  widx  = paddr[4:2];
   wire [31:0] max_f = (widx == 3'h0) ? MAX_IN_W - 1 : (widx == 3'h1) ? MAX_IN_H - 1 :
                       (widx == 3'h2) ? MAX_OUT_W - 1 : MAX_OUT_H - 1;
   // Output pixel rounding, four fraction bits; the scaler fixes the mode at build time
   function automatic [7:0] round_px(input [11:0] v, input [1:0] mode);
      reg up;
      begin
         up = (v[3] && v[2:0] != 3'h0) || (v[3:0] == 4'h8 && v[4]);
         case (mode)
            2'h0:    round_px = v[11:4];
            2'h1:    round_px = v[11:4] + {7'h00, v[3]};
            default: round_px = v[11:4] + {7'h00, up};
         endcase
      end
   endfunction
   // Data of the previous address; the hole toggles so stale data never pass
   assign prdat = (radr_r[4:2] == 3'h7) ? {32{fs_cnt_r[0]}} : stage_r[radr_r[4:2]];
   // Staging, update on frame sync, and a count of out-of-range size writes
   // One shared clock here, so the request needs no clock crossing
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stage_r[0] <= MAX_IN_W - 1;
         stage_r[1] <= MAX_IN_H - 1;
         stage_r[2] <= MAX_OUT_W - 1;
         stage_r[3] <= MAX_OUT_H - 1;
         for (k = 4; k < 7; k = k + 1) stage_r[k] <= 32'h0;
         work_r[0] <= MAX_IN_W - 1;
         work_r[1] <= MAX_IN_H - 1;
         work_r[2] <= MAX_OUT_W - 1;
         work_r[3] <= MAX_OUT_H - 1;
         work_r[4] <= 32'h0;
         work_r[5] <= 32'h0;
         radr_r    <= 5'h00;
         fs_cnt_r  <= 16'h0000;
         bad_wr_r  <= 32'h0;
      end else begin
         radr_r   <= paddr;
         fs_cnt_r <= (fs_cnt_r == FS_GAP - 1) ? 16'h0000 : fs_cnt_r + 16'h0001;
         if (pwrite && widx == 3'h6) stage_r[6] <= pwdat;
         else if (pwrite && widx < 3'h6 && !stage_r[6][0]) stage_r[widx] <= pwdat;
         if (pwrite && widx < 3'h4 && (pwdat < 32'h1f || pwdat > max_f))
            bad_wr_r <= bad_wr_r + 32'h1;
         if (fs_cnt_r == 16'h0000 && stage_r[6][0]) begin
            for (k = 0; k < 6; k = k + 1) work_r[k] <= stage_r[k];
            stage_r[6] <= 32'h0;
         end
      end
   end
endmodule // scdu_dev_model

// ===== verif/scdu_host_tb.sv
// Self-checking bench for the scaler parameter-update host controller.
// Assumes the device model stands on the parameter bus and shares clk.
`timescale 1ns/1ps
`include "scdu_defs.vh"
module scdu_host_tb;
   localparam MAXV = 256;
   localparam PB   = 9;            // log2 of 256, raised to the coefficient width
   localparam ALL  = 32'hffffffff;
   reg          clk      = 1'b0;
   reg          arst_n   = 1'b0;
   reg  [3:0]   sw_addr  = 4'h0;
   reg  [31:0]  sw_wdata = 32'h0;
   reg          sw_wr    = 1'b0;
   reg          sw_rd    = 1'b0;
   wire [31:0]  sw_rdata;
   wire         pwrite;
   wire [4:0]   paddr;
   wire [31:0]  pwdat;
   wire [31:0]  prdat;
   logic [63:0] exp_q [$];
   logic [63:0] ent;
   logic        rd_d     = 1'b0;
   logic [31:0] f [0:3];
   logic [31:0] vf;
   logic [31:0] hf;
   int          mismatches = 0;
   int          checks     = 0;
   int          nwr        = 0;
   int          n0;
   int          i;

   always #4 clk = ~clk;

   scdu_host #(.MAX_IN_W(MAXV), .MAX_IN_H(MAXV), .MAX_OUT_W(MAXV), .MAX_OUT_H(MAXV),
      .SMALL_KERN(1)) scdu_host_inst (
      .clk(clk), .arst_n(arst_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
      .sw_rd(sw_rd), .sw_rdata(sw_rdata), .pwrite(pwrite), .paddr(paddr), .pwdat(pwdat),
      .prdat(prdat));
   scdu_dev_model #(.MAX_IN_W(MAXV), .MAX_IN_H(MAXV), .MAX_OUT_W(MAXV), .MAX_OUT_H(MAXV))
      scdu_dev_model_inst (
      .clk(clk), .arst_n(arst_n), .pwrite(pwrite), .paddr(paddr), .pwdat(pwdat),
      .prdat(prdat));

   task automatic stop_test();
      $display("mismatches %0d checks %0d", mismatches, checks);
      if (mismatches == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] expv);
      checks++;
      if (seen !== expv) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask

   task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      sw_addr  <= a;
      sw_wdata <= d;
      sw_wr    <= 1'b1;
      @(posedge clk);
      sw_wr    <= 1'b0;
   endtask

   // Mask of zero marks a read whose data only steer the bench
   task automatic sw_read(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge clk);
      exp_q.push_back({m, e});
      sw_addr <= a;
      sw_rd   <= 1'b1;
      @(posedge clk);
      sw_rd   <= 1'b0;
   endtask

   // Poll status until busy drops, bounded so a stuck device cannot hang us
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         sw_read(`SCDU_CMD_STATUS, 32'h0, 32'h0);
         @(negedge clk);
         n++;
      end while (sw_rdata[`SCDU_ST_BUSY_BIT] !== 1'b0 && n < 400);
      if (n >= 400) mismatches++;
   endtask

   // Legal configuration: 1 all minimum, 2 all maximum, else random
   task automatic run_cfg(input int mode, input logic yuv);
      for (int k = 0; k < 4; k++) begin
         f[k] = (mode == 1) ? 32'h1f : (mode == 2) ? MAXV - 1 : 32'h1f + $urandom_range(MAXV - 32);
         if (yuv && k % 2 == 0) f[k] = f[k] | 32'h1;
         sw_write(k[3:0], f[k]);
      end
      vf = ((f[1] + 1) << PB) / (f[3] + 1);
      hf = ((f[0] + 1) << PB) / (f[2] + 1);
      n0 = nwr;
      sw_write(`SCDU_CMD_CONTROL, {30'h0, yuv, 1'b1});
      sw_write(`SCDU_CMD_IN_WIDTH, f[0] ^ 32'h2);
      wait_idle();
      check(32'(nwr - n0), 32'h7);
      for (int k = 0; k < 4; k++) check(scdu_dev_model_inst.work_r[k], f[k]);
      check(scdu_dev_model_inst.work_r[4], vf);
      check(scdu_dev_model_inst.work_r[5], hf);
      check(scdu_dev_model_inst.stage_r[6], 32'h0);
      sw_write(`SCDU_CMD_VSCALE, $urandom);
      sw_read(`SCDU_CMD_VSCALE, vf, ALL);
      sw_read(`SCDU_CMD_HSCALE, hf, ALL);
      sw_read(`SCDU_CMD_IN_WIDTH, f[0], ALL);
      sw_read(`SCDU_CMD_STATUS, 32'h0, 32'h3);
   endtask

   // Illegal configuration: refused with the error flag and no parameter writes
   task automatic run_bad(input int k, input logic [31:0] v, input logic yuv);
      for (int j = 0; j < 4; j++) sw_write(j[3:0], (j == k) ? v : 32'h65);
      n0 = nwr;
      sw_write(`SCDU_CMD_CONTROL, {30'h0, yuv, 1'b1});
      wait_idle();
      check(32'(nwr - n0), 32'h0);
      sw_read(`SCDU_CMD_STATUS, 32'h2, 32'h3);
   endtask

   // Results appear one cycle after the read strobe
   always @(posedge clk) begin
      if (rd_d) begin
         ent = exp_q.pop_front();
         if (ent[63:32] != 32'h0) check(sw_rdata & ent[63:32], ent[31:0]);
      end
      rd_d <= sw_rd;
      if (pwrite === 1'b1) nwr++;
   end

   initial begin
      i = $urandom(32'h17dbb4fb);
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      sw_write(4'h9, $urandom);
      for (i = 0; i < 4; i++) begin
         sw_read(i[3:0], MAXV - 1, ALL);
         check(scdu_dev_model_inst.work_r[i], MAXV - 1);
      end
      sw_read(`SCDU_CMD_STATUS, 32'h0, 32'h7);
      check(scdu_dev_model_inst.stage_r[6], 32'h0);
      run_cfg(1, 1'b1);
      run_cfg(2, 1'b0);
      run_cfg(0, 1'b0);
      run_cfg(0, 1'b1);
      run_bad(0, 32'h1e, 1'b0);
      run_bad(3, 32'h100, 1'b0);
      run_bad(0, 32'h64, 1'b1);
      run_bad(2, 32'h40, 1'b1);
      check(scdu_dev_model_inst.bad_wr_r, 32'h0);
      check(scdu_dev_model_inst.round_px(12'h028, 2'h0), 32'h2);
      check(scdu_dev_model_inst.round_px(12'h028, 2'h1), 32'h3);
      check(scdu_dev_model_inst.round_px(12'h027, 2'h1), 32'h2);
      check(scdu_dev_model_inst.round_px(12'h028, 2'h2), 32'h2);
      check(scdu_dev_model_inst.round_px(12'h038, 2'h2), 32'h4);
      check(scdu_dev_model_inst.round_px(12'h029, 2'h2), 32'h3);
      repeat (4) @(posedge clk);
      stop_test();
   end

   // Whole run needs about 1300 cycles; this cuts a hang short
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      stop_test();
   end
endmodule // scdu_host_tb
